/* File: fsic_defs.vh */
// fsic_defs.vh: opcodes, status bit positions and timing counts for the
// status and identification command block; included by the design file only.
`ifndef FSIC_DEFS_VH
`define FSIC_DEFS_VH
`define FSIC_OP_STATUS_READ   8'h05
`define FSIC_OP_LATCH_CLEAR   8'h04
`define FSIC_OP_JEDEC_IDENT   8'h9F
`define FSIC_OP_LEGACY_ID_A   8'h90
`define FSIC_OP_LEGACY_ID_B   8'hAB
`define FSIC_OP_LATCH_SET     8'h06
`define FSIC_OP_ARM           8'h50
`define FSIC_OP_STATUS_WRITE  8'h01
`define FSIC_BIT_BUSY         0
`define FSIC_BIT_WPL          1
`define FSIC_BIT_LVL_LO       2
`define FSIC_BIT_AAI          6
`define FSIC_BIT_LOCK         7
`define FSIC_RST_LOCK         1'b1
`define FSIC_RST_LEVELS       4'hF
`define FSIC_SYNC_IDLE        4'h9
`define FSIC_ADDR_BITS        24
`define FSIC_PROG_TIME_US     10
`define FSIC_CLK_MHZ          40
`define FSIC_PROG_CYCLES      (`FSIC_PROG_TIME_US * `FSIC_CLK_MHZ)
`endif

/* File: fsic_core.v */
// fsic_core.v: serial flash status-register and identification command
// interpreter. assumes the spi pins are asynchronous to clk_sys, mode 0,
// and that the serial clock is at most a quarter of clk_sys.
// status fields and busy leave as plain ports; program_start and
// auto_increment_set come from array logic already on clk_sys.
`timescale 1ns/10ps
`include "fsic_defs.vh"

// Operation
// - status read answered even while busy
// - status byte repeats until select rises
// - latch-set sets write permit latch
// - status write clears latch at end
// - latch-set executes on select rise
// - latch-clear clears latch and auto-increment
// - latch-clear leaves running program alone
// - arm opens one status write
// - status write loads levels and lock
// - locked and pin low ignores write
// - pin low: lock only sets, never clears
// - pin high: all protect bits writable
// - unlocked or pin high permits write
// - jedec ident: maker, type, capacity
// - jedec ident ends on select rise
// - two legacy opcodes take 24-bit address
// - legacy ident alternates maker and device
// - opcode 04 is latch-clear
// - opcode 05 is status read
module fsic_core #(
    parameter [7:0] OP_LATCH_SET    = `FSIC_OP_LATCH_SET,
    parameter [7:0] OP_ARM          = `FSIC_OP_ARM,
    parameter [7:0] OP_STATUS_WRITE = `FSIC_OP_STATUS_WRITE,
    parameter [7:0] MAKER_CODE      = 8'h5A,  // arbitrary identity value
    parameter [7:0] TYPE_CODE       = 8'h3C,  // arbitrary identity value
    parameter [7:0] CAP_CODE        = 8'h11,  // arbitrary identity value
    parameter       PROG_CYCLES     = `FSIC_PROG_CYCLES
) (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       chip_select_n,
    input  wire       serial_clk,
    input  wire       serial_in,
    input  wire       protect_pin_n,
    input  wire       program_start,
    input  wire       auto_increment_set,
    output reg        serial_out,
    output reg        serial_out_en,
    output reg        write_permit_latch,
    output reg        auto_increment_flag,
    output reg        protect_lock_bit,
    output reg  [3:0] protect_level_bits,
    output reg        busy
);
    // command phases
    localparam [2:0] PH_OPCODE = 3'd0;
    localparam [2:0] PH_STATUS = 3'd1;
    localparam [2:0] PH_JEDEC  = 3'd2;
    localparam [2:0] PH_ADDR   = 3'd3;
    localparam [2:0] PH_LEGACY = 3'd4;
    localparam [2:0] PH_WDATA  = 3'd5;
    localparam [2:0] PH_IDLE   = 3'd6;

    // execute codes latched at opcode end, acted on at select rise
    localparam [1:0] EX_NONE  = 2'd0;
    localparam [1:0] EX_SET   = 2'd1;
    localparam [1:0] EX_CLEAR = 2'd2;
    localparam [1:0] EX_ARM   = 2'd3;

    // two-stage synchronisers for every pin
    reg  [3:0] sync_a;
    reg  [3:0] sync_b;
    reg        sclk_prev;
    reg        cs_prev;
    wire       cs_n  = sync_b[0];
    wire       sclk  = sync_b[1];
    wire       sdi   = sync_b[2];
    wire       wp_n  = sync_b[3];
    wire       rise  = sclk & ~sclk_prev;
    wire       fall  = ~sclk & sclk_prev;
    wire       cs_up = cs_n & ~cs_prev;

    // decoder and readout state
    reg  [2:0]  phase;
    reg  [4:0]  bit_cnt;
    reg  [7:0]  shift_in;
    reg  [7:0]  tx_byte;
    reg  [2:0]  tx_cnt;
    reg  [1:0]  jedec_idx;
    reg         legacy_sel;

    // actions held back until the select rise that executes them
    reg  [1:0]  exec_code;
    reg         armed;
    reg         wr_pending;
    reg  [7:0]  wr_data;

    // program timer; only a start and its own count move it
    reg  [31:0] prog_cnt;

    // values derived from the state above
    wire [7:0]  next_shift = {shift_in[6:0], sdi};
    wire [7:0]  status_byte;
    wire        write_go;
    wire        write_open;
    wire        next_lock;

    // status byte built from the field positions, so a move is one edit
    assign status_byte[`FSIC_BIT_LOCK]        = protect_lock_bit;
    assign status_byte[`FSIC_BIT_AAI]         = auto_increment_flag;
    assign status_byte[`FSIC_BIT_LVL_LO +: 4] = protect_level_bits;
    assign status_byte[`FSIC_BIT_WPL]         = write_permit_latch;
    assign status_byte[`FSIC_BIT_BUSY]        = busy;

    // a staged write runs only when armed or latched, and only while the pin
    // is high or the lock is clear; a refused write still drops the latch
    assign write_go   = wr_pending & (armed | write_permit_latch);
    assign write_open = wp_n | ~protect_lock_bit;
    // with the pin low the lock can only be raised, never dropped
    assign next_lock  = wp_n ? wr_data[`FSIC_BIT_LOCK] :
                        (protect_lock_bit | wr_data[`FSIC_BIT_LOCK]);

    // pins cross into clk_sys before anything reads them
    always @(posedge clk_sys) begin
        if (rst) begin
            // idle pin levels, so no false clock edge or select rise follows reset
            sync_a    <= `FSIC_SYNC_IDLE;
            sync_b    <= `FSIC_SYNC_IDLE;
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b1;
        end else begin
            sync_a    <= {protect_pin_n, serial_in, serial_clk, chip_select_n};
            sync_b    <= sync_a;
            sclk_prev <= sync_b[1];
            cs_prev   <= sync_b[0];
        end
    end

    // shift engine: opcode decode, address capture and output selection
    always @(posedge clk_sys) begin
        if (rst) begin
            phase         <= PH_OPCODE;
            bit_cnt       <= 5'h00;
            shift_in      <= 8'h00;
            tx_byte       <= 8'h00;
            tx_cnt        <= 3'h0;
            jedec_idx     <= 2'h0;
            legacy_sel    <= 1'b0;
            exec_code     <= EX_NONE;
            wr_pending    <= 1'b0;
            wr_data       <= 8'h00;
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end else if (cs_n) begin
            // select high ends every readout and resets the decoder
            phase         <= PH_OPCODE;
            bit_cnt       <= 5'h00;
            serial_out_en <= 1'b0;
            if (cs_up) begin
                exec_code  <= EX_NONE;
                wr_pending <= 1'b0;
            end
        end else if (rise) begin
            // one bit in per synced serial clock rise, msb first
            shift_in <= next_shift;
            bit_cnt  <= bit_cnt + 5'h01;
            case (phase)
                PH_OPCODE: begin
                    if (bit_cnt == 5'd7) begin
                        bit_cnt <= 5'h00;
                        tx_cnt  <= 3'h0;
                        phase   <= PH_IDLE;
                        // status read is always decoded, busy or not
                        if (next_shift == `FSIC_OP_STATUS_READ) begin
                            phase   <= PH_STATUS;
                            tx_byte <= status_byte;
                        end else if (next_shift == `FSIC_OP_JEDEC_IDENT) begin
                            phase     <= PH_JEDEC;
                            tx_byte   <= MAKER_CODE;
                            jedec_idx <= 2'h1;
                        end else if (next_shift == `FSIC_OP_LEGACY_ID_A ||
                                     next_shift == `FSIC_OP_LEGACY_ID_B) begin
                            phase <= PH_ADDR;
                        end else if (next_shift == `FSIC_OP_LATCH_CLEAR) begin
                            exec_code <= EX_CLEAR;
                        end else if (next_shift == OP_LATCH_SET) begin
                            exec_code <= EX_SET;
                        end else if (next_shift == OP_ARM) begin
                            exec_code <= EX_ARM;
                        end else if (next_shift == OP_STATUS_WRITE) begin
                            phase <= PH_WDATA;
                        end
                    end
                end
                PH_ADDR: begin
                    if (bit_cnt == 5'd23) begin
                        // address lsb picks the first byte out
                        phase      <= PH_LEGACY;
                        tx_cnt     <= 3'h0;
                        tx_byte    <= next_shift[0] ? CAP_CODE : MAKER_CODE;
                        legacy_sel <= ~next_shift[0];
                    end
                end
                PH_WDATA: begin
                    // staged only; it acts at the select rise, so a cut frame writes nothing
                    if (bit_cnt == 5'd7) begin
                        wr_data    <= next_shift;
                        wr_pending <= 1'b1;
                        phase      <= PH_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (fall) begin
            // output changes on the falling edge, msb first
            if (phase == PH_STATUS || phase == PH_JEDEC || phase == PH_LEGACY) begin
                serial_out_en <= 1'b1;
                serial_out    <= tx_byte[3'd7 - tx_cnt];
                tx_cnt        <= tx_cnt + 3'h1;
                if (tx_cnt == 3'd7) begin
                    case (phase)
                        PH_STATUS: tx_byte <= status_byte;
                        PH_JEDEC: begin
                            // type, then capacity, then zeros until select rises
                            if (jedec_idx != 2'h3)
                                jedec_idx <= jedec_idx + 2'h1;
                            case (jedec_idx)
                                2'h1:    tx_byte <= TYPE_CODE;
                                2'h2:    tx_byte <= CAP_CODE;
                                default: tx_byte <= 8'h00;
                            endcase
                        end
                        PH_LEGACY: begin
                            tx_byte    <= legacy_sel ? CAP_CODE : MAKER_CODE;
                            legacy_sel <= ~legacy_sel;
                        end
                        default: tx_byte <= 8'h00;
                    endcase
                end
            end
        end
    end

    // latch, lock and level bits change only at the select rise that ends a command; auto-increment can set in any cycle
    always @(posedge clk_sys) begin
        if (rst) begin
            write_permit_latch  <= 1'b0;
            auto_increment_flag <= 1'b0;
            protect_lock_bit    <= `FSIC_RST_LOCK;
            protect_level_bits  <= `FSIC_RST_LEVELS;
            armed               <= 1'b0;
        end else begin
            if (cs_up) begin
                // every completed command drops the arm, the write included; only an arm command sets it again
                armed <= 1'b0;
                case (exec_code)
                    EX_SET: write_permit_latch <= 1'b1;
                    EX_CLEAR: begin
                        write_permit_latch  <= 1'b0;
                        auto_increment_flag <= 1'b0;
                    end
                    EX_ARM: armed <= 1'b1;
                    default: begin
                    end
                endcase
                if (write_go) begin
                    write_permit_latch <= 1'b0;
                    if (write_open) begin
                        protect_level_bits <= wr_data[`FSIC_BIT_LVL_LO +: 4];
                        protect_lock_bit   <= next_lock;
                    end
                end
            end
            // placed last so a set beats a latch-clear landing in the same cycle
            if (auto_increment_set && write_permit_latch) begin
                auto_increment_flag <= 1'b1;
            end
        end
    end

    // busy timer: a program needs the latch and is never cut short
    always @(posedge clk_sys) begin
        if (rst) begin
            prog_cnt <= 32'h0;
            busy     <= 1'b0;
        end else if (program_start && write_permit_latch && !busy) begin
            // a start during a running program is dropped, not queued
            prog_cnt <= PROG_CYCLES;
            busy     <= 1'b1;
        end else if (prog_cnt != 32'h0) begin
            // latch-clear does not touch this count
            prog_cnt <= prog_cnt - 32'h1;
            busy     <= (prog_cnt != 32'h1);
        end
    end

endmodule // fsic_core

/* File: fsic_core_assertions.sv */
// fsic_core_assertions.sv: port-level checks for the status and ident block.
// assumes it is bound to fsic_core and that selects stay high for 8 cycles.
`timescale 1ns/10ps
module fsic_core_assertions #(
    parameter PROG_CYCLES = 8
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       chip_select_n,
    input wire logic       serial_clk,
    input wire logic       serial_in,
    input wire logic       protect_pin_n,
    input wire logic       program_start,
    input wire logic       auto_increment_set,
    input wire logic       serial_out,
    input wire logic       serial_out_en,
    input wire logic       write_permit_latch,
    input wire logic       auto_increment_flag,
    input wire logic       protect_lock_bit,
    input wire logic [3:0] protect_level_bits,
    input wire logic       busy
);
    int run;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // length of the current busy stretch; a helper since the count is too long to unroll
    always @(posedge clk_sys) run <= (rst || !busy) ? 0 : run + 1;
    rst_vals_a: assert property ($fell(rst) |-> protect_lock_bit && protect_level_bits == 4'hF
        && !write_permit_latch && !auto_increment_flag && !busy) else $error("bad reset state");
    en_idle_a: assert property (chip_select_n [*8] |-> !serial_out_en)
        else $error("output enabled while deselected");
    latch_exec_a: assert property ($rose(write_permit_latch) |-> chip_select_n
        && $past(chip_select_n)) else $error("latch set before select rose");
    lvl_exec_a: assert property ($changed(protect_level_bits) |-> chip_select_n)
        else $error("levels changed inside a frame");
    lock_keep_a: assert property ($fell(protect_lock_bit) |-> $past(protect_pin_n, 3))
        else $error("lock cleared with pin low");
    lock_ignore_a: assert property ($changed(protect_level_bits)
        |-> !$past(protect_lock_bit) || $past(protect_pin_n, 3)) else $error("locked write taken");
    busy_len_a: assert property ($fell(busy) |-> run >= PROG_CYCLES - 1
        && run <= PROG_CYCLES + 1) else $error("busy stretch has wrong length");
    aai_rise_a: assert property ($rose(auto_increment_flag) |-> $past(write_permit_latch))
        else $error("auto increment set without latch");
endmodule // fsic_core_assertions

/* File: fsic_host.sv */
// fsic_host.sv: behavioural spi host, mode 0, 200 ns serial clock.
// assumes clk_sys at 40 MHz; pins change only at its falling edge.
`timescale 1ns/10ps
module fsic_host (
    input  wire logic clk_sys,
    input  wire logic serial_out,
    output logic      chip_select_n,
    output logic      serial_clk,
    output logic      serial_in
);
    // serial clock stands low between frames
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end
    // one framed transfer, msb first; read bits sampled late in the high phase
    task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        @(negedge clk_sys);
        chip_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in = tx[n - 1 - i];
            repeat (4) @(negedge clk_sys);
            serial_clk = 1'b1;
            repeat (4) @(negedge clk_sys);
            rx = {rx[62:0], serial_out};
            serial_clk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        chip_select_n = 1'b1;
        serial_in = ~serial_in; // released line must not keep its value
        repeat (8) @(negedge clk_sys);
    endtask
endmodule // fsic_host

/* File: fsic_core_tb.sv */
// fsic_core_tb.sv: self-checking bench for the status and ident commands.
// assumes fsic_host drives the spi pins and the checker is bound below.
`timescale 1ns/10ps
module fsic_core_tb;
    localparam [7:0] MK = 8'h5A; // arbitrary identity value
    localparam [7:0] TY = 8'h3C; // arbitrary identity value
    localparam [7:0] CP = 8'h11; // arbitrary identity value
    logic        clk_sys = 0, rst = 1, protect_pin_n = 1;
    logic        program_start = 0, auto_increment_set = 0;
    wire         chip_select_n, serial_clk, serial_in, serial_out, serial_out_en;
    wire         write_permit_latch, auto_increment_flag, protect_lock_bit, busy;
    wire   [3:0] protect_level_bits;
    wire   [7:0] stat = {protect_lock_bit, auto_increment_flag, protect_level_bits,
                         write_permit_latch, busy};
    int          err_count = 0, cmp_count = 0, cycles = 0;
    logic [63:0] rx;
    fsic_core #(.PROG_CYCLES(400), .MAKER_CODE(MK), .TYPE_CODE(TY), .CAP_CODE(CP)) fsic_core_inst (
        .clk_sys(clk_sys), .rst(rst), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .protect_pin_n(protect_pin_n), .program_start(program_start),
        .auto_increment_set(auto_increment_set), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .write_permit_latch(write_permit_latch),
        .auto_increment_flag(auto_increment_flag), .protect_lock_bit(protect_lock_bit),
        .protect_level_bits(protect_level_bits), .busy(busy));
    fsic_host fsic_host_inst (.clk_sys(clk_sys), .serial_out(serial_out),
        .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in));
    always #12.5 clk_sys = ~clk_sys;
    // hang guard, well above the few thousand cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task cmd(input logic [63:0] tx, input int n);
        fsic_host_inst.frame(tx, n, rx);
    endtask
    task results;
        if (err_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task t_read; // reset state, then repeated status byte
        check({stat, serial_out_en}, 9'h178);
        cmd(64'h05_0000, 24);
        check(rx[15:0], 16'hBCBC);
    endtask
    task t_latch; // pin high: latch-set permits one write, which clears it
        cmd(64'h06, 8);
        check(write_permit_latch, 1'b1);
        cmd(64'h0100, 16);
        check(stat, 8'h00);
        cmd(64'h013C, 16);
        check(stat, 8'h00);
    endtask
    task t_lock; // pin low lock-down
        @(negedge clk_sys) protect_pin_n = 1'b0;
        cmd(64'h50, 8);
        cmd(64'h0194, 16);
        check(stat, 8'h94);
        cmd(64'h50, 8);
        cmd(64'h0100, 16);
        check(stat, 8'h94);
        @(negedge clk_sys) protect_pin_n = 1'b1;
        cmd(64'h50, 8);
        cmd(64'h0100, 16);
        check(stat, 8'h00);
        cmd(64'h50, 8);
        cmd(64'h0500, 16);
        cmd(64'h013C, 16);
        check(stat, 8'h00);
    endtask
    task t_clear; // latch-clear during a running program
        cmd(64'h06, 8);
        @(negedge clk_sys) auto_increment_set = 1'b1;
        @(negedge clk_sys) auto_increment_set = 1'b0;
        cmd(64'h0500, 16);
        check(rx[7:0], 8'h42);
        @(negedge clk_sys) program_start = 1'b1;
        @(negedge clk_sys) program_start = 1'b0;
        cmd(64'h0500, 16);
        check(rx[0], 1'b1);
        cmd(64'h04, 8);
        check({auto_increment_flag, write_permit_latch, busy}, 3'b001);
        for (int w = 0; w < 500 && busy !== 1'b0; w++) @(negedge clk_sys);
        check(busy, 1'b0);
    endtask
    task t_ident; // standard ident, then two legacy opcodes
        cmd(64'h9F_0000_0000, 40);
        check(rx[31:0], {MK, TY, CP, 8'h00});
        check(serial_out_en, 1'b0);
        for (int k = 0; k < 2; k++) begin
            cmd({k ? 8'hAB : 8'h90, 23'h0, k[0], 16'h0}, 48);
            check(rx[15:0], k ? {CP, MK} : {MK, CP});
        end
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        t_read();
        t_latch();
        t_lock();
        t_clear();
        t_ident();
        results();
    end
endmodule // fsic_core_tb
bind fsic_core fsic_core_assertions #(.PROG_CYCLES(PROG_CYCLES)) fsic_core_assertions_inst (
    .clk_sys(clk_sys), .rst(rst), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .protect_pin_n(protect_pin_n), .program_start(program_start),
    .auto_increment_set(auto_increment_set), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .write_permit_latch(write_permit_latch),
    .auto_increment_flag(auto_increment_flag), .protect_lock_bit(protect_lock_bit),
    .protect_level_bits(protect_level_bits), .busy(busy));
